// *** io_bus_defines.svh ***
`ifndef IO_BUS_DEFINES_SVH
`define IO_BUS_DEFINES_SVH

`define EB_W            16
`define EB_AUX_BIT      15
`define EB_OUT_BIT      14
`define EB_IN_BIT       13
`define EB_SENSE_BIT    12
`define EB_EXT_BIT      11
`define EB_CLR_BIT      8
`define EB_FUNC_MSB     8
`define EB_FUNC_LSB     6
`define EB_DEV_MSB      5
`define EB_DEV_LSB      0
`define DEV_W           6
`define FUNC_W          3
`define CODE_W          9
`define CLK_NS          25
`define TRAP_NS         2700
`define SCAN_NS         1800
`define ICLK_NS         909
`define TRAP_CYC        ((`TRAP_NS + `CLK_NS - 1) / `CLK_NS)
`define SCAN_CYC        (`SCAN_NS / `CLK_NS)
`define ICLK_HALF_CYC   ((`ICLK_NS / `CLK_NS) / 2)
`define IO_CYC          2
`define ZERO16          16'h0000

`endif

// *** io_bus_peripheral_model.sv ***
`timescale 1ns/1ps
module io_bus_peripheral_model #(
    parameter logic [5:0] MY_ADDR = 6'h3f
) (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic [15:0] i_eb_out,
    input  wire logic        i_eb_oe_n,
    input  wire logic        i_function_ready_strobe,
    input  wire logic        i_auto_request,
    input  wire logic [15:0] i_reply_word,
    input  wire logic [7:0]  i_line_state,
    input  wire logic [15:0] i_vector,
    output logic             o_drive,
    output logic [15:0]      o_eb_in,
    output logic             o_sense_reply_line
);
    logic        sel_reg;
    logic        sense_reg;
    logic [2:0]  func_reg;
    logic [15:0] churn_reg;

    // Selected for the one cycle after a data-in or sense function word with our address
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sel_reg   <= 1'b0;
            sense_reg <= 1'b0;
            func_reg  <= 3'h0;
            churn_reg <= 16'h0000;
        end else begin
            sel_reg   <= i_function_ready_strobe && !i_eb_oe_n && (i_eb_out[5:0] == MY_ADDR)
                         && (i_eb_out[13] || i_eb_out[12]);
            sense_reg <= i_eb_out[12];
            func_reg  <= i_eb_out[8:6];
            churn_reg <= churn_reg + 16'h3b1d;
        end
    end

    // Released lines show a changing pattern so a stale value never passes
    assign o_drive            = i_auto_request || (sel_reg && !sense_reg);
    assign o_eb_in            = i_auto_request ? i_vector :
                                (sel_reg && !sense_reg) ? i_reply_word : churn_reg;
    assign o_sense_reply_line = (sel_reg && sense_reg) ? i_line_state[func_reg] : churn_reg[0];
endmodule

// *** io_bus_pkg.sv ***
package io_bus_pkg;
    typedef enum logic [3:0] {
        OP_NONE      = 4'b0000,
        OP_EXT       = 4'b0001,
        OP_EXT_AUX   = 4'b0010,
        OP_SENSE     = 4'b0011,
        OP_IN_REG    = 4'b0100,
        OP_IN_MEM    = 4'b0101,
        OP_OUT_REG   = 4'b0110,
        OP_OUT_MEM   = 4'b0111
    } io_op_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_FUNC   = 3'b001,
        ST_DATA   = 3'b010,
        ST_DONE   = 3'b011,
        ST_TRAP   = 3'b100,
        ST_INTR   = 3'b101
    } seq_state_t;

    typedef enum logic [1:0] {
        SRV_NONE  = 2'b00,
        SRV_POWER = 2'b01,
        SRV_BUS   = 2'b10,
        SRV_CONS  = 2'b11
    } service_t;
endpackage

// *** io_bus_program_transfer.sv ***
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "io_bus_defines.svh"

module io_bus_program_transfer #(
    parameter int WORD_W = `EB_W
) (
    input  wire logic                i_clk,
    input  wire logic                i_arst_n,
    input  wire logic                i_op_valid,
    input  wire io_bus_pkg::io_op_t  i_op,
    input  wire logic [`CODE_W-1:0]  i_code,
    input  wire logic                i_reg_sel_b,
    input  wire logic                i_clear,
    input  wire logic [WORD_W-1:0]   i_reg_a,
    input  wire logic [WORD_W-1:0]   i_reg_b,
    input  wire logic [WORD_W-1:0]   i_mem_word,
    input  wire logic [WORD_W-1:0]   i_eb_in,
    input  wire logic                i_sense_reply_line,
    input  wire logic                i_trap_read_request,
    input  wire logic                i_trap_write_request,
    input  wire logic                i_bus_intr_request,
    input  wire logic                i_power_fail,
    input  wire logic                i_console_intr,
    output logic [WORD_W-1:0]        o_eb_out,
    output logic                     o_eb_oe_n,
    output logic                     o_function_ready_strobe,
    output logic                     o_word_ready_strobe,
    output logic                     o_priority_scan_clock,
    output logic                     o_busy,
    output logic                     o_reg_we,
    output logic                     o_reg_we_b,
    output logic [WORD_W-1:0]        o_reg_wdata,
    output logic                     o_mem_we,
    output logic [WORD_W-1:0]        o_mem_wdata,
    output logic                     o_jump,
    output logic                     o_next_seq,
    output logic                     o_intr_fetch,
    output logic [WORD_W-1:0]        o_intr_addr,
    output logic                     o_trap_active,
    output logic                     o_trap_read,
    output logic [WORD_W-1:0]        o_trap_addr,
    output io_bus_pkg::service_t     o_service
);
    import io_bus_pkg::*;

    localparam int SCAN_CYC  = `SCAN_CYC;
    localparam int TRAP_CYC  = `TRAP_CYC;
    localparam int ICLK_HALF = `ICLK_HALF_CYC;

    seq_state_t          state_reg;
    io_op_t              op_reg;
    logic                auto_win;
    logic                sel_b_reg;
    logic                clear_reg;
    logic [WORD_W-1:0]   src_reg;
    logic [7:0]          cnt_reg;
    logic [7:0]          scan_cnt_reg;
    logic [7:0]          iclk_cnt_reg;
    logic                scan_tick;

    // Function-ready word: class bit, function digit and device select field
    function automatic logic [WORD_W-1:0] fry_word(input io_op_t op, input logic [`CODE_W-1:0] code,
                                                   input logic clr);
        logic [WORD_W-1:0] w;
        w = '0;
        w[`EB_DEV_MSB:`EB_DEV_LSB] = code[`DEV_W-1:0];
        case (op)
            OP_EXT: begin
                w[`EB_EXT_BIT] = 1'b1;
                w[`EB_FUNC_MSB:`EB_FUNC_LSB] = code[`CODE_W-1:`DEV_W];
            end
            OP_EXT_AUX: begin
                w[`EB_AUX_BIT] = 1'b1;
                w[`EB_FUNC_MSB:`EB_FUNC_LSB] = code[`CODE_W-1:`DEV_W];
            end
            OP_SENSE: begin
                w[`EB_SENSE_BIT] = 1'b1;
                w[`EB_FUNC_MSB:`EB_FUNC_LSB] = code[`CODE_W-1:`DEV_W];
            end
            OP_IN_REG, OP_IN_MEM: begin
                w[`EB_IN_BIT] = 1'b1;
                w[`EB_CLR_BIT] = clr && (op == OP_IN_REG);
            end
            OP_OUT_REG, OP_OUT_MEM: begin
                w[`EB_OUT_BIT] = 1'b1;
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction

    // Interrupt clock for party-line users
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            iclk_cnt_reg          <= 8'h00;
            o_priority_scan_clock <= 1'b0;
        end else if (iclk_cnt_reg == 8'(ICLK_HALF - 1)) begin
            iclk_cnt_reg          <= 8'h00;
            o_priority_scan_clock <= ~o_priority_scan_clock;
        end else begin
            iclk_cnt_reg <= iclk_cnt_reg + 8'h01;
        end
    end

    // Priority scan period
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            scan_cnt_reg <= 8'h00;
        end else if (scan_tick) begin
            scan_cnt_reg <= 8'h00;
        end else begin
            scan_cnt_reg <= scan_cnt_reg + 8'h01;
        end
    end
    assign scan_tick = (scan_cnt_reg == 8'(SCAN_CYC - 1));
    // A won scan pre-empts a program request, so the bus stays free for the requester
    assign auto_win  = scan_tick && !i_power_fail
                       && (i_trap_read_request || i_trap_write_request || i_bus_intr_request);

    // Winner of each scan; daisy chain already settled the bus requester
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_service <= SRV_NONE;
        end else if (scan_tick) begin
            if (i_power_fail) begin
                o_service <= SRV_POWER;
            end else if (i_bus_intr_request || i_trap_read_request || i_trap_write_request) begin
                o_service <= SRV_BUS;
            end else if (i_console_intr) begin
                o_service <= SRV_CONS;
            end else begin
                o_service <= SRV_NONE;
            end
        end
    end

    // Sequencer; automatic sequences start only between program operations
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= ST_IDLE;
            op_reg    <= OP_NONE;
            sel_b_reg <= 1'b0;
            clear_reg <= 1'b0;
            src_reg   <= '0;
            cnt_reg   <= 8'h00;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 8'h00;
                    if (scan_tick && !i_power_fail && (i_trap_read_request || i_trap_write_request)) begin
                        state_reg <= ST_TRAP;
                        op_reg    <= OP_NONE;
                    end else if (scan_tick && !i_power_fail && i_bus_intr_request) begin
                        state_reg <= ST_INTR;
                    end else if (i_op_valid && i_op != OP_NONE) begin
                        state_reg <= ST_FUNC;
                        op_reg    <= i_op;
                        sel_b_reg <= i_reg_sel_b;
                        clear_reg <= i_clear;
                        src_reg   <= (i_op == OP_OUT_MEM) ? i_mem_word : (i_reg_sel_b ? i_reg_b : i_reg_a);
                    end
                end
                ST_FUNC: begin
                    state_reg <= ST_DATA;
                end
                ST_DATA: begin
                    if (cnt_reg == 8'(`IO_CYC - 2)) begin
                        state_reg <= ST_DONE;
                    end
                    cnt_reg <= cnt_reg + 8'h01;
                end
                ST_TRAP: begin
                    if (cnt_reg == 8'(TRAP_CYC - 1)) begin
                        state_reg <= ST_DONE;
                    end
                    cnt_reg <= cnt_reg + 8'h01;
                end
                ST_INTR: begin
                    state_reg <= ST_DONE;
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                    op_reg    <= OP_NONE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Bus drive; data-in and sense leave the data phase to the controller
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_eb_out                <= `ZERO16;
            o_eb_oe_n               <= 1'b1;
            o_function_ready_strobe <= 1'b0;
            o_word_ready_strobe     <= 1'b0;
        end else begin
            o_function_ready_strobe <= (state_reg == ST_IDLE) && i_op_valid && i_op != OP_NONE && !auto_win;
            o_word_ready_strobe     <= 1'b0;
            o_eb_oe_n               <= 1'b1;
            o_eb_out                <= `ZERO16;
            if (state_reg == ST_IDLE && i_op_valid && !auto_win) begin
                o_eb_out  <= fry_word(i_op, i_code, i_clear);
                o_eb_oe_n <= (i_op == OP_NONE);
            end else if (state_reg == ST_FUNC && (op_reg == OP_OUT_REG || op_reg == OP_OUT_MEM)) begin
                o_eb_out            <= src_reg;
                o_eb_oe_n           <= 1'b0;
                o_word_ready_strobe <= 1'b1;
            end else if (state_reg == ST_FUNC && (op_reg == OP_IN_REG || op_reg == OP_IN_MEM)) begin
                o_word_ready_strobe <= 1'b1;
            end
        end
    end

    // Results of input, sense and interrupt sequences
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_we      <= 1'b0;
            o_reg_we_b    <= 1'b0;
            o_reg_wdata   <= `ZERO16;
            o_mem_we      <= 1'b0;
            o_mem_wdata   <= `ZERO16;
            o_jump        <= 1'b0;
            o_next_seq    <= 1'b0;
            o_intr_fetch  <= 1'b0;
            o_intr_addr   <= `ZERO16;
        end else begin
            o_reg_we     <= 1'b0;
            o_mem_we     <= 1'b0;
            o_jump       <= 1'b0;
            o_next_seq   <= 1'b0;
            o_intr_fetch <= 1'b0;
            if (state_reg == ST_DATA && cnt_reg == 8'h00) begin
                if (op_reg == OP_IN_REG) begin
                    o_reg_we    <= 1'b1;
                    o_reg_we_b  <= sel_b_reg;
                    // Clear first, so OR with zero is a plain load
                    o_reg_wdata <= i_eb_in | (clear_reg ? `ZERO16 : (sel_b_reg ? i_reg_b : i_reg_a));
                end else if (op_reg == OP_IN_MEM) begin
                    o_mem_we    <= 1'b1;
                    o_mem_wdata <= i_eb_in;
                end else if (op_reg == OP_SENSE) begin
                    o_jump      <= i_sense_reply_line;
                    o_next_seq  <= !i_sense_reply_line;
                end
            end
            if (state_reg == ST_INTR) begin
                o_intr_fetch <= 1'b1;
                o_intr_addr  <= i_eb_in;
            end
        end
    end

    // Trap suspension; the requester's address is latched on entry
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_trap_active <= 1'b0;
            o_trap_read   <= 1'b0;
            o_trap_addr   <= `ZERO16;
            o_busy        <= 1'b0;
        end else begin
            o_busy <= (state_reg != ST_IDLE) || (i_op_valid && i_op != OP_NONE);
            if (state_reg == ST_IDLE && scan_tick && !i_power_fail
                && (i_trap_read_request || i_trap_write_request)) begin
                o_trap_active <= 1'b1;
                o_trap_read   <= i_trap_read_request;
                o_trap_addr   <= i_eb_in;
            end else if (state_reg == ST_TRAP && cnt_reg == 8'(TRAP_CYC - 1)) begin
                o_trap_active <= 1'b0;
            end
        end
    end

    AST_TRAP_LEN: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $rose(o_trap_active) |-> ##[TRAP_CYC:TRAP_CYC] $fell(o_trap_active))
        else $error("Trap suspension length wrong");

    AST_EXT_CLASS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_function_ready_strobe && $past(i_op) == OP_EXT |-> o_eb_out[15:11] == 5'b00001)
        else $error("External control class bits wrong");

    AST_OUT_CLASS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_function_ready_strobe && $past(i_op) inside {OP_OUT_REG, OP_OUT_MEM} |-> o_eb_out[15:11] == 5'b01000)
        else $error("Data out class bits wrong");

    AST_IN_CLASS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_function_ready_strobe && $past(i_op) inside {OP_IN_REG, OP_IN_MEM} |-> o_eb_out[15:11] == 5'b00100)
        else $error("Data in class bits wrong");

    AST_SENSE_CLASS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_function_ready_strobe && $past(i_op) == OP_SENSE
        |-> o_eb_out[15:11] == 5'b00010 && o_eb_out[8:0] == $past(i_code))
        else $error("Sense word wrong");

    AST_AUX_CLASS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_function_ready_strobe && $past(i_op) == OP_EXT_AUX |-> o_eb_out[15:11] == 5'b10000)
        else $error("Aux control class bits wrong");

    AST_WORD_AFTER_FUNC: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_function_ready_strobe && $past(i_op) inside {OP_OUT_REG, OP_OUT_MEM}
        |=> o_word_ready_strobe && !o_eb_oe_n)
        else $error("Word strobe missing after output function");

    AST_POWER_FIRST: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        scan_tick && i_power_fail |=> o_service == SRV_POWER)
        else $error("Power failure not top priority");

    AST_CONSOLE_LAST: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        scan_tick && (i_bus_intr_request || i_trap_read_request) |=> o_service != SRV_CONS)
        else $error("Console accepted over bus request");

    AST_SENSE_SPLIT: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !(o_jump && o_next_seq))
        else $error("Sense both jumped and continued");
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import io_bus_pkg::*;
    localparam int TRAP_CYCLES = 2700 / 25;
    localparam int SCAN_CYCLES = 1800 / 25;
    logic        i_clk, i_arst_n, i_op_valid, i_reg_sel_b, i_clear, i_sense_reply_line;
    logic        i_trap_read_request, i_trap_write_request, i_bus_intr_request, i_power_fail, i_console_intr;
    io_op_t      i_op;
    logic [8:0]  i_code;
    logic [15:0] i_reg_a, i_reg_b, i_mem_word, i_eb_in, o_eb_out, o_reg_wdata, o_mem_wdata;
    logic [15:0] o_intr_addr, o_trap_addr, p_eb, reply_word, vector;
    logic        o_eb_oe_n, o_function_ready_strobe, o_word_ready_strobe, o_priority_scan_clock, o_busy;
    logic        o_reg_we, o_reg_we_b, o_mem_we, o_jump, o_next_seq, o_intr_fetch, o_trap_active, o_trap_read;
    logic        p_drive;
    logic [7:0]  line_state;
    service_t    o_service;
    int          seed, miscompares, comparisons, fry_cnt, we_cnt, n;

    assign i_eb_in = (p_drive || o_eb_oe_n) ? p_eb : o_eb_out;

    io_bus_program_transfer i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_op_valid(i_op_valid), .i_op(i_op),
        .i_code(i_code), .i_reg_sel_b(i_reg_sel_b), .i_clear(i_clear), .i_reg_a(i_reg_a), .i_reg_b(i_reg_b),
        .i_mem_word(i_mem_word), .i_eb_in(i_eb_in), .i_sense_reply_line(i_sense_reply_line),
        .i_trap_read_request(i_trap_read_request), .i_trap_write_request(i_trap_write_request),
        .i_bus_intr_request(i_bus_intr_request), .i_power_fail(i_power_fail), .i_console_intr(i_console_intr),
        .o_eb_out(o_eb_out), .o_eb_oe_n(o_eb_oe_n), .o_function_ready_strobe(o_function_ready_strobe),
        .o_word_ready_strobe(o_word_ready_strobe), .o_priority_scan_clock(o_priority_scan_clock),
        .o_busy(o_busy), .o_reg_we(o_reg_we), .o_reg_we_b(o_reg_we_b), .o_reg_wdata(o_reg_wdata),
        .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_jump(o_jump), .o_next_seq(o_next_seq),
        .o_intr_fetch(o_intr_fetch), .o_intr_addr(o_intr_addr), .o_trap_active(o_trap_active),
        .o_trap_read(o_trap_read), .o_trap_addr(o_trap_addr), .o_service(o_service));

    io_bus_peripheral_model i_peer (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_eb_out(o_eb_out),
        .i_eb_oe_n(o_eb_oe_n), .i_function_ready_strobe(o_function_ready_strobe),
        .i_auto_request(i_trap_read_request | i_trap_write_request | i_bus_intr_request),
        .i_reply_word(reply_word), .i_line_state(line_state), .i_vector(vector), .o_drive(p_drive),
        .o_eb_in(p_eb), .o_sense_reply_line(i_sense_reply_line));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        if (o_function_ready_strobe === 1'b1) fry_cnt++;
        if ((o_reg_we | o_mem_we) === 1'b1) we_cnt++;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (miscompares == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic step;
        @(posedge i_clk);
        #1;
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: pick = o_function_ready_strobe;
            1: pick = o_word_ready_strobe;
            2: pick = o_reg_we | o_mem_we;
            3: pick = o_jump | o_next_seq;
            4: pick = !o_busy;
            5: pick = o_trap_active;
            default: pick = o_intr_fetch;
        endcase
    endfunction

    task automatic wait_hi(input int w, input int lim);
        int k;
        k = 0;
        while (pick(w) !== 1'b1 && k < lim) begin
            step();
            k++;
        end
        if (pick(w) !== 1'b1) begin
            miscompares++;
            $display("mismatch wait_%0d expected 1 seen 0", w);
        end
    endtask

    // Expected function word; bits 10:9 unused, bits 7:6 don't-care on data ops
    function automatic logic [15:0] fword(input io_op_t op, input logic [8:0] code, input logic clr);
        case (op)
            OP_EXT:             fword = 16'h0800 | {7'h00, code};
            OP_EXT_AUX:         fword = 16'h8000 | {7'h00, code};
            OP_SENSE:           fword = 16'h1000 | {7'h00, code};
            OP_IN_REG, OP_IN_MEM: fword = 16'h2000 | {7'h00, clr, 2'h0, code[5:0]};
            default:            fword = 16'h4000 | {10'h000, code[5:0]};
        endcase
    endfunction

    task automatic do_op(input io_op_t op, input logic [8:0] code, input logic clr, input logic selb,
                         input logic extra);
        logic [15:0] ra, rb, mw, word, msk;
        logic [7:0]  lines;
        int          f0, w0;
        ra = 16'($random(seed));
        rb = 16'($random(seed));
        mw = 16'($random(seed));
        word = 16'($random(seed));
        lines = 8'($random(seed));
        msk = (op >= OP_IN_REG) ? 16'hf93f : 16'hf9ff;
        @(posedge i_clk);
        i_op_valid <= 1'b1;
        i_op <= op;
        i_code <= code;
        i_clear <= clr;
        i_reg_sel_b <= selb;
        i_reg_a <= ra;
        i_reg_b <= rb;
        i_mem_word <= mw;
        reply_word <= word;
        line_state <= lines;
        f0 = fry_cnt;
        w0 = we_cnt;
        @(posedge i_clk);
        i_op_valid <= 1'b0;
        #1;
        wait_hi(0, 4);
        check("function_word", o_eb_out & msk, fword(op, code, clr));
        check("drive_enable_n", {15'h0000, o_eb_oe_n}, 16'h0000);
        // A second request while busy must be ignored
        if (extra) fork
            begin
                @(posedge i_clk);
                i_op_valid <= 1'b1;
                @(posedge i_clk);
                i_op_valid <= 1'b0;
            end
        join_none
        case (op)
            OP_OUT_REG, OP_OUT_MEM: begin
                wait_hi(1, 4);
                check("out_word", o_eb_out, (op == OP_OUT_MEM) ? mw : (selb ? rb : ra));
            end
            OP_IN_REG: begin
                wait_hi(2, 6);
                check("reg_word", o_reg_wdata, clr ? word : ((selb ? rb : ra) | word));
                check("reg_select", {15'h0000, o_reg_we_b}, {15'h0000, selb});
            end
            OP_IN_MEM: begin
                wait_hi(2, 6);
                check("mem_word", o_mem_wdata, word);
                check("mem_strobe", {15'h0000, o_mem_we}, 16'h0001);
            end
            OP_SENSE: begin
                wait_hi(3, 6);
                check("sense_result", {14'h0000, o_jump, o_next_seq},
                      {14'h0000, lines[code[8:6]], !lines[code[8:6]]});
            end
            default: ;
        endcase
        wait_hi(4, 12);
        step();
        check("fry_count", 16'(fry_cnt - f0), 16'h0001);
        check("write_count", 16'(we_cnt - w0), (op == OP_IN_REG || op == OP_IN_MEM) ? 16'h0001 : 16'h0000);
    endtask

    initial begin
        #500000;
        miscompares++;
        stop_test();
    end

    initial begin
        io_op_t     op;
        logic [8:0] code;
        seed = 32'h9c06_fb2e;
        {i_arst_n, i_op_valid, i_reg_sel_b, i_clear, i_trap_read_request, i_trap_write_request} = 6'h00;
        {i_bus_intr_request, i_power_fail, i_console_intr} = 3'h0;
        i_op = OP_NONE;
        {i_code, i_reg_a, i_reg_b, i_mem_word, reply_word, vector, line_state} = '0;
        repeat (4) @(posedge i_clk);
        #1;
        check("reset_idle", {o_eb_oe_n, o_busy, o_function_ready_strobe, o_eb_out[12:0]}, 16'h8000);
        @(posedge i_clk);
        i_arst_n <= 1'b1;
        // Interrupt clock period in system clocks
        n = 0;
        while (o_priority_scan_clock !== 1'b0 && n < 100) begin step(); n++; end
        while (o_priority_scan_clock !== 1'b1 && n < 100) begin step(); n++; end
        n = 0;
        while (o_priority_scan_clock === 1'b1 && n < 100) begin step(); n++; end
        while (o_priority_scan_clock !== 1'b1 && n < 100) begin step(); n++; end
        check("scan_clock_period", 16'(n), 16'h0024);
        for (int i = 0; i < 49; i++) begin
            op = io_op_t'(4'(1 + i % 7));
            code = 9'($random(seed));
            if (i < 7) code[5:0] = 6'h00;
            if (op == OP_IN_REG || op == OP_IN_MEM || op == OP_SENSE) code[5:0] = 6'h3f;
            do_op(op, code, (op == OP_IN_REG) ? 1'($random(seed)) : 1'b0, 1'($random(seed)),
                  (op >= OP_IN_REG) && i[1]);
        end
        for (int r = 0; r < 2; r++) begin
            @(posedge i_clk);
            vector <= 16'($random(seed));
            i_trap_read_request <= (r == 0);
            i_trap_write_request <= (r == 1);
            #1;
            wait_hi(5, SCAN_CYCLES + 8);
            check("trap_addr", o_trap_addr, vector);
            check("trap_dir", {15'h0000, o_trap_read}, {15'h0000, r == 0});
            @(posedge i_clk);
            {i_trap_read_request, i_trap_write_request} <= 2'h0;
            #1;
            n = 1;
            while (o_trap_active === 1'b1 && n < 300) begin step(); n++; end
            check("trap_length", 16'(n), 16'(TRAP_CYCLES));
        end
        @(posedge i_clk);
        {i_power_fail, i_trap_write_request, i_console_intr} <= 3'h7;
        n = 0;
        repeat (2 * SCAN_CYCLES + 4) begin step(); if (o_trap_active === 1'b1) n++; end
        check("trap_under_power_fail", 16'(n), 16'h0000);
        check("service_power", {14'h0000, o_service}, {14'h0000, SRV_POWER});
        @(posedge i_clk);
        {i_power_fail, i_trap_write_request, i_bus_intr_request} <= 3'h1;
        vector <= 16'($random(seed));
        #1;
        wait_hi(6, SCAN_CYCLES + 8);
        check("intr_addr", o_intr_addr, vector);
        check("service_bus", {14'h0000, o_service}, {14'h0000, SRV_BUS});
        @(posedge i_clk);
        i_bus_intr_request <= 1'b0;
        repeat (SCAN_CYCLES + 8) step();
        check("service_console", {14'h0000, o_service}, {14'h0000, SRV_CONS});
        i_console_intr <= 1'b0;
        stop_test();
    end
endmodule
